/* File: adsc_act_model.sv */
// Actuator model that presents one state snapshot to the status block.
// Assumes the bench loads a requested state; it shows from the next rising edge.
module adsc_act_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire adsc_pkg::adsc_snap_t req_i,
  output adsc_pkg::adsc_snap_t snap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // coherent snapshot
  // All fields move at one edge, so the block never samples a torn state.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      snap_o <= '0;
    end else if (load_i) begin
      snap_o <= req_i;
    end
  end
endmodule

/* File: adsc_irq.sv */
// Sticky event flags with a mask and one level interrupt.
// Assumes the caller supplies per-bit clear pulses already qualified by a bus write.
module adsc_irq #(
  parameter int unsigned W = 17
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] event_i,
  input wire logic [W-1:0] clear_i,
  input wire logic mask_we_i,
  input wire logic [W-1:0] mask_i,
  output logic [W-1:0] status_o,
  output logic [W-1:0] mask_o,
  output logic irq_o
);

  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  logic [W-1:0] mask_q;
  logic [W-1:0] mask_d;
  logic irq_q;

  // A new event in the clearing cycle survives the clear.
  always_comb begin
    status_d = (status_q & ~clear_i) | event_i;
    mask_d = mask_we_i ? mask_i : mask_q;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_q <= adsc_pkg::IRQ_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Built from the next values so the line tracks the flags with no extra lag.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_d);
    end
  end

  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = irq_q;

endmodule

/* File: adsc_pkg.sv */
// Shared constants and carriers for the actuator discrete status channels.
// Assumes one 20 MHz system clock and an APB master on the register side.
package adsc_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned POS_W = 8;
  localparam int unsigned CHAN_W = 17;
  localparam int unsigned FIRST_CHANNEL = 8;

  // Byte offsets of the register words.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CHAN = 12'h004;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;

  // Field positions inside the control word.
  localparam int unsigned CTRL_LOWER_LSB = 0;
  localparam int unsigned CTRL_UPPER_LSB = 8;
  localparam int unsigned CTRL_HWMODE_BIT = 16;

  // Values after reset.
  localparam logic [7:0] LOWER_TRIG_RST = 8'h00;
  localparam logic [7:0] UPPER_TRIG_RST = 8'h64;
  localparam logic HWMODE_RST = 1'b0;
  localparam logic [16:0] CHAN_RST = 17'h00000;
  localparam logic [16:0] IRQ_MASK_RST = 17'h00000;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

  // One coherent sample of the actuator state, synchronous to the clock.
  typedef struct packed {
    logic [7:0] position;
    logic fully_open;
    logic fully_closed;
    logic drive_open;
    logic drive_close;
    logic onoff_service;
    logic timer_active;
    logic timer_off_period;
    logic step_delay;
    logic interlock_active;
    logic open_alarm_trip;
    logic close_alarm_trip;
    logic emergency_shutdown_active;
    logic open_interlock_run;
    logic close_interlock_run;
    logic [2:0] discrete_status_input;
  } adsc_snap_t;

  // Channels 8 to 24; channel 8 sits in bit 0.
  typedef struct packed {
    logic [2:0] hw_input;
    logic interlock_any;
    logic close_interlock;
    logic open_interlock;
    logic emergency_shutdown_active;
    logic close_unavailable;
    logic open_unavailable;
    logic motion_inhibited;
    logic moving;
    logic closing;
    logic opening;
    logic at_upper;
    logic at_lower;
    logic toward_open_flag;
    logic toward_close_flag;
  } adsc_chan_t;

endpackage

/* File: adsc_tb_top.sv */
// Bench for the discrete status channels: APB master, actuator model, checks.
// Assumes zero or few APB wait states and a one-cycle channel latency.
module adsc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic ld = 1'b0;
  adsc_pkg::adsc_snap_t req = '0;
  adsc_pkg::adsc_snap_t snap;
  adsc_pkg::adsc_snap_t s;
  adsc_pkg::adsc_chan_t chan_o;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, irq_o;
  logic [33:0] q[$];
  logic [33:0] qe;
  int error_cnt = 0;
  int num_checks = 0;
  integer seed = 32'hE3243313;
  logic [31:0] r;
  logic [7:0] lo = 8'h00;
  logic [7:0] hi = 8'h64;
  logic hw = 1'b0;
  logic st8 = 1'b0;
  logic [16:0] cur = 17'h00000;
  logic [16:0] stat = 17'h00000;
  logic [16:0] msk = 17'h00000;
  logic [9:0] tbl = 10'h1CC;

  always #25 clk_sys_i = ~clk_sys_i;

  adsc_act_model act (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .load_i(ld),
    .req_i(req), .snap_o(snap));
  adsc_top uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .snap_i(snap), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .chan_o(chan_o),
    .irq_o(irq_o));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic adsc_pkg::adsc_chan_t exp_of(input adsc_pkg::adsc_snap_t x);
    adsc_pkg::adsc_chan_t c;
    c = '0;
    c.toward_close_flag = st8;
    c.toward_open_flag = ~st8;
    c.at_lower = x.position <= lo;
    c.at_upper = x.position >= hi;
    c.opening = x.drive_open & ~x.drive_close;
    c.closing = x.drive_close & ~x.drive_open;
    c.moving = c.opening | c.closing;
    c.motion_inhibited = x.onoff_service ? x.timer_active & x.timer_off_period : x.step_delay;
    c.open_unavailable = x.interlock_active | x.open_alarm_trip;
    c.close_unavailable = x.interlock_active | x.close_alarm_trip;
    c.emergency_shutdown_active = x.emergency_shutdown_active;
    c.open_interlock = x.open_interlock_run;
    c.close_interlock = x.close_interlock_run;
    c.interlock_any = x.open_interlock_run | x.close_interlock_run;
    c.hw_input = hw ? 3'h0 : x.discrete_status_input;
    return c;
  endfunction

  // The expectation is queued first; the watcher below compares it at the answer.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic er);
    int n;
    q.push_back({~wr, er, e});
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    // The request stands until the rising edge at which pready is seen high.
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  always @(posedge clk_sys_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && q.size() > 0) begin
      qe = q.pop_front();
      if (qe[33]) chk(prdata_o, qe[31:0]);
      chk({31'h00000000, pslverr_o}, {31'h00000000, qe[32]});
    end
  end

  task automatic settle();
    adsc_pkg::adsc_chan_t c;
    if (req.fully_open) st8 = 1'b1;
    else if (req.fully_closed) st8 = 1'b0;
    c = exp_of(req);
    stat = stat | (cur ^ c);
    cur = c;
    repeat (3) @(negedge clk_sys_i);
    chk({15'h0000, chan_o}, {15'h0000, c});
    chk({31'h00000000, irq_o}, {31'h00000000, |(stat & msk)});
    apb(1'b0, adsc_pkg::OFS_CHAN, 32'h00000000, {15'h0000, c}, 1'b0);
  endtask

  task automatic put(input adsc_pkg::adsc_snap_t x);
    @(posedge clk_sys_i);
    req <= x;
    ld <= 1'b1;
    @(posedge clk_sys_i);
    ld <= 1'b0;
    settle();
  endtask

  task automatic wctrl(input logic [7:0] l, input logic [7:0] h, input logic m);
    lo = l;
    hi = h;
    hw = m;
    apb(1'b1, adsc_pkg::OFS_CTRL, {15'h0000, m, h, l}, 32'h00000000, 1'b0);
    apb(1'b0, adsc_pkg::OFS_CTRL, 32'h00000000, {15'h0000, m, h, l}, 1'b0);
    settle();
  endtask

  task automatic wmask(input logic [16:0] m);
    msk = m;
    apb(1'b1, adsc_pkg::OFS_IRQ_MASK, {15'h0000, m}, 32'h00000000, 1'b0);
    apb(1'b0, adsc_pkg::OFS_IRQ_MASK, 32'h00000000, {15'h0000, m}, 1'b0);
  endtask

  task automatic clr(input logic [16:0] v);
    apb(1'b0, adsc_pkg::OFS_IRQ_STATUS, 32'h00000000, {15'h0000, stat}, 1'b0);
    apb(1'b1, adsc_pkg::OFS_IRQ_STATUS, {15'h0000, v}, 32'h00000000, 1'b0);
    stat = stat & ~v;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    settle();
    apb(1'b0, adsc_pkg::OFS_CTRL, 32'h00000000, 32'h00006400, 1'b0);
    apb(1'b0, adsc_pkg::OFS_IRQ_MASK, 32'h00000000, 32'h00000000, 1'b0);
    apb(1'b0, 12'h010, 32'h00000000, 32'h00000000, 1'b1);
    apb(1'b1, 12'hFFC, 32'hFFFFFFFF, 32'h00000000, 1'b1);
    apb(1'b1, adsc_pkg::OFS_CHAN, 32'hFFFFFFFF, 32'h00000000, 1'b0);
    settle();
    clr(17'h1FFFF);
    $display("test reset and map done");
    s = '0;
    for (int i = 0; i < 5; i++) begin
      {s.fully_open, s.fully_closed} = tbl[2*(4-i) +: 2];
      put(s);
    end
    $display("test end positions done");
    wmask(17'h00010);
    clr(17'h1FFFF);
    for (int i = 1; i < 5; i++) begin
      {s.drive_open, s.drive_close} = i[1:0];
      put(s);
      clr(17'h00010);
    end
    $display("test motion and interrupt done");
    wctrl(8'h20, 8'h40, 1'b0);
    foreach (tbl[i]) begin
      s.position = (i < 5) ? 8'h1D + 8'(i) : 8'h3E + 8'(i - 5);
      put(s);
    end
    s.discrete_status_input = 3'h5;
    put(s);
    wctrl(8'h20, 8'h40, 1'b1);
    wctrl(8'h20, 8'h40, 1'b0);
    $display("test triggers and inputs done");
    for (int i = 0; i < 64; i++) begin
      {s.onoff_service, s.timer_active, s.timer_off_period, s.step_delay} = i[3:0];
      {s.interlock_active, s.open_alarm_trip} = i[5:4];
      put(s);
    end
    for (int i = 0; i < 16; i++) begin
      {s.close_alarm_trip, s.emergency_shutdown_active} = i[3:2];
      {s.open_interlock_run, s.close_interlock_run} = i[1:0];
      put(s);
    end
    $display("test inhibit and interlock done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      if (i % 8 == 0) wmask(r[16:0]);
      if (i % 8 == 4) wctrl(r[7:0], r[15:8], r[16]);
      if (i % 8 == 6) clr(r[16:0]);
      r = $random(seed);
      put(r[25:0]);
    end
    clr(17'h1FFFF);
    settle();
    $display("test random done");
    // A reset in mid-run must clear every channel and the interrupt line.
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    req <= '0;
    repeat (2) @(negedge clk_sys_i);
    chk({15'h0000, chan_o}, 32'h00000000);
    chk({31'h00000000, irq_o}, 32'h00000000);
    @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    st8 = 1'b0;
    hw = adsc_pkg::HWMODE_RST;
    lo = adsc_pkg::LOWER_TRIG_RST;
    hi = adsc_pkg::UPPER_TRIG_RST;
    msk = adsc_pkg::IRQ_MASK_RST;
    stat = 17'h00000;
    cur = 17'h00000;
    settle();
    apb(1'b0, adsc_pkg::OFS_CTRL, 32'h00000000, 32'h00006400, 1'b0);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule

/* File: adsc_top.sv */
// Discrete status channels 8 to 24 of a valve actuator, with an APB register slave.
// Assumes the actuator snapshot is synchronous to clk_sys_i and coherent per cycle.
//
// Behaviour
// - channel 8 is 0 travelling toward open, 1 toward closed.
// - channel 9 is the inverse of channel 8.
// - channel 10 set when position is at or below the lower trigger.
// - channel 11 set when position is at or above the upper trigger.
// - channel 12 set exactly while travelling in the opening direction.
// - channel 13 set exactly while travelling in the closing direction.
// - channel 14 set while moving in either direction.
// - channel 15 marks timer off period or positioning step delay.
// - channel 16 set when open is blocked by interlock or opening alarm.
// - channel 17 set when close is blocked by interlock or closing alarm.
// - channel 18 set while emergency shutdown is active.
// - channel 19 set while an opening interlock runs.
// - channel 20 set while a closing interlock runs.
// - channel 21 set while either interlock operation runs.
// - channels 22 to 24 show digital inputs only with hardwired mode off.
// - end positions are single bits that flip the channel 8 and 9 sense.
module adsc_top (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire adsc_pkg::adsc_snap_t snap_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output adsc_pkg::adsc_chan_t chan_o,
  output logic irq_o
);

  adsc_pkg::adsc_chan_t chan_q;
  adsc_pkg::adsc_chan_t chan_d;
  logic toggle_q;
  logic [7:0] lower_trig_q;
  logic [7:0] upper_trig_q;
  logic hw_mode_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic run_q;
  logic [16:0] irq_status;
  logic [16:0] irq_mask;
  logic irq_w;
  logic setup_w;
  logic commit_w;
  logic wr_ctrl_w;
  logic wr_status_w;
  logic wr_mask_w;
  logic [16:0] clear_w;
  logic [31:0] rdata_w;
  logic mapped_w;
  logic open_only_w;
  logic close_only_w;
  logic toggle_d;
  logic at_lower_w;
  logic at_upper_w;

  // Compares a position against a trigger; used for both thresholds.
  function automatic logic pos_le(input logic [7:0] a, input logic [7:0] b);
    pos_le = (a <= b);
  endfunction

  // Decodes one register offset against the word-aligned bus address.
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr[11:2] == ofs[11:2]);
  endfunction

  // direction exclusive
  // A snapshot claiming both drives is treated as no motion rather than guessing.
  assign open_only_w = snap_i.drive_open & ~snap_i.drive_close;
  assign close_only_w = snap_i.drive_close & ~snap_i.drive_open;

  // end position sense
  // Reaching fully open flips the sense to closing; fully closed flips it back.
  always_comb begin
    if (snap_i.fully_open) begin
      toggle_d = 1'b1;
    end else if (snap_i.fully_closed) begin
      toggle_d = 1'b0;
    end else begin
      toggle_d = toggle_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  assign at_lower_w = pos_le(snap_i.position, lower_trig_q);
  assign at_upper_w = pos_le(upper_trig_q, snap_i.position);

  always_comb begin
    chan_d.toward_close_flag = toggle_d;
    chan_d.toward_open_flag = ~toggle_d;
    chan_d.at_lower = at_lower_w;
    chan_d.at_upper = at_upper_w;
    chan_d.opening = open_only_w;
    chan_d.closing = close_only_w;
    chan_d.moving = open_only_w | close_only_w;
    if (snap_i.onoff_service) begin
      chan_d.motion_inhibited = snap_i.timer_active & snap_i.timer_off_period;
    end else begin
      chan_d.motion_inhibited = snap_i.step_delay;
    end
    chan_d.open_unavailable = snap_i.interlock_active | snap_i.open_alarm_trip;
    chan_d.close_unavailable = snap_i.interlock_active | snap_i.close_alarm_trip;
    chan_d.emergency_shutdown_active = snap_i.emergency_shutdown_active;
    chan_d.open_interlock = snap_i.open_interlock_run;
    chan_d.close_interlock = snap_i.close_interlock_run;
    chan_d.interlock_any = snap_i.open_interlock_run | snap_i.close_interlock_run;
    chan_d.hw_input = snap_i.discrete_status_input & {3{~hw_mode_q}};
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_q <= adsc_pkg::CHAN_RST;
    end else begin
      chan_q <= chan_d;
    end
  end

  // Marks the cycles after the first edge out of reset, for the checks below.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
    end
  end

  // The slave answers with one wait-free access phase: pready is raised at the
  // setup edge, so read data is sampled then and may miss a change one cycle later.
  assign setup_w = psel_i & ~penable_i & ~pready_q;
  assign commit_w = psel_i & penable_i & pready_q;
  assign mapped_w = hit(paddr_i, adsc_pkg::OFS_CTRL) | hit(paddr_i, adsc_pkg::OFS_CHAN) |
                    hit(paddr_i, adsc_pkg::OFS_IRQ_STATUS) | hit(paddr_i, adsc_pkg::OFS_IRQ_MASK);
  assign wr_ctrl_w = commit_w & pwrite_i & ~pslverr_q & hit(paddr_i, adsc_pkg::OFS_CTRL);
  assign wr_status_w = commit_w & pwrite_i & ~pslverr_q &
                       hit(paddr_i, adsc_pkg::OFS_IRQ_STATUS);
  assign wr_mask_w = commit_w & pwrite_i & ~pslverr_q & hit(paddr_i, adsc_pkg::OFS_IRQ_MASK);
  assign clear_w = wr_status_w ? pwdata_i[16:0] : 17'h00000;

  always_comb begin
    rdata_w = adsc_pkg::RDATA_RST;
    if (hit(paddr_i, adsc_pkg::OFS_CTRL)) begin
      rdata_w[adsc_pkg::CTRL_LOWER_LSB +: 8] = lower_trig_q;
      rdata_w[adsc_pkg::CTRL_UPPER_LSB +: 8] = upper_trig_q;
      rdata_w[adsc_pkg::CTRL_HWMODE_BIT] = hw_mode_q;
    end else if (hit(paddr_i, adsc_pkg::OFS_CHAN)) begin
      rdata_w[16:0] = chan_q;
    end else if (hit(paddr_i, adsc_pkg::OFS_IRQ_STATUS)) begin
      rdata_w[16:0] = irq_status;
    end else if (hit(paddr_i, adsc_pkg::OFS_IRQ_MASK)) begin
      rdata_w[16:0] = irq_mask;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= adsc_pkg::RDATA_RST;
    end else if (setup_w) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped_w;
      prdata_q <= pwrite_i ? adsc_pkg::RDATA_RST : rdata_w;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= adsc_pkg::RDATA_RST;
    end
  end

  // Trigger writes take effect at the completing edge and steer channels 10 and 11.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lower_trig_q <= adsc_pkg::LOWER_TRIG_RST;
      upper_trig_q <= adsc_pkg::UPPER_TRIG_RST;
      hw_mode_q <= adsc_pkg::HWMODE_RST;
    end else if (wr_ctrl_w) begin
      lower_trig_q <= pwdata_i[adsc_pkg::CTRL_LOWER_LSB +: 8];
      upper_trig_q <= pwdata_i[adsc_pkg::CTRL_UPPER_LSB +: 8];
      hw_mode_q <= pwdata_i[adsc_pkg::CTRL_HWMODE_BIT];
    end
  end

  // Any change of a channel, either edge, is an event for software.
  adsc_irq #(
    .W(adsc_pkg::CHAN_W)
  ) u_irq (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .event_i(chan_d ^ chan_q),
    .clear_i(clear_w),
    .mask_we_i(wr_mask_w),
    .mask_i(pwdata_i[16:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_w)
  );

  assign chan_o = chan_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign irq_o = irq_w;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  toggle_open_a: assert property (snap_i.fully_open |=> chan_q.toward_close_flag)
    else $error("channel 8 not set after fully open");
  toggle_close_a: assert property (
    (snap_i.fully_closed && !snap_i.fully_open) |=> !chan_q.toward_close_flag)
    else $error("channel 8 not cleared after fully closed");
  sense_inverse_a: assert property (run_q |-> (chan_q.toward_open_flag != chan_q.toward_close_flag))
    else $error("channel 9 not inverse of channel 8");
  lower_trig_a: assert property (
    run_q |-> chan_q.at_lower == ($past(snap_i.position) <= $past(lower_trig_q)))
    else $error("channel 10 disagrees with lower trigger");
  upper_trig_a: assert property (
    run_q |-> chan_q.at_upper == ($past(snap_i.position) >= $past(upper_trig_q)))
    else $error("channel 11 disagrees with upper trigger");
  open_flag_a: assert property (
    (snap_i.drive_open && !snap_i.drive_close) |=> (chan_q.opening && !chan_q.closing))
    else $error("channel 12 missed opening");
  close_flag_a: assert property (
    (snap_i.drive_close && !snap_i.drive_open) |=> (chan_q.closing && !chan_q.opening))
    else $error("channel 13 missed closing");
  dir_excl_a: assert property (!(chan_q.opening && chan_q.closing))
    else $error("opening and closing set together");
  moving_any_a: assert property (chan_q.moving == (chan_q.opening || chan_q.closing))
    else $error("channel 14 disagrees with direction flags");
  inhibit_sel_a: assert property (
    snap_i.onoff_service |=> chan_q.motion_inhibited ==
      ($past(snap_i.timer_active) && $past(snap_i.timer_off_period)))
    else $error("channel 15 wrong in on/off service");
  open_block_a: assert property (
    (snap_i.interlock_active || snap_i.open_alarm_trip) |=> chan_q.open_unavailable)
    else $error("channel 16 missed a blocking cause");
  close_block_a: assert property (
    !(snap_i.interlock_active || snap_i.close_alarm_trip) |=> !chan_q.close_unavailable)
    else $error("channel 17 set with closing available");
  esd_follow_a: assert property (
    run_q |-> chan_q.emergency_shutdown_active == $past(snap_i.emergency_shutdown_active))
    else $error("channel 18 does not follow shutdown");
  ilk_open_a: assert property (snap_i.open_interlock_run |=> chan_q.open_interlock)
    else $error("channel 19 missed opening interlock");
  ilk_close_a: assert property (snap_i.close_interlock_run |=> chan_q.close_interlock)
    else $error("channel 20 missed closing interlock");
  ilk_any_a: assert property (
    chan_q.interlock_any == (chan_q.open_interlock || chan_q.close_interlock))
    else $error("channel 21 disagrees with interlock flags");
  hw_gate_a: assert property (hw_mode_q |=> (chan_q.hw_input == 3'h0))
    else $error("digital input reported in hardwired mode");
  reset_clear_a: assert property (!run_q |-> (chan_q == adsc_pkg::CHAN_RST))
    else $error("channels not clear after reset");
  bus_ready_a: assert property (pready_q |=> !pready_q)
    else $error("pready held longer than one cycle");
  irq_level_a: assert property (irq_w == |(irq_status & irq_mask))
    else $error("interrupt level disagrees with flags");

endmodule
